// [src/afcany_pkg.sv]
package afcany_pkg;
	localparam int CLK_MHZ = 200;
	// fifo thresholds are counted in 64-byte units
	localparam int THR_UNIT_LOG2 = 6;
	// jam durations at 100 Mbit/s, in ns
	localparam int DUR_CODE0_NS = 5000;
	localparam int DUR_CODE1_NS = 10000;
	localparam int DUR_CODE2_NS = 15000;
	localparam int DUR_CODE3_NS = 25000;
	localparam int DUR_CODE4_NS = 50000;
	localparam int DUR_CODE5_NS = 100000;
	localparam int DUR_STEP_NS  = 50000;
	// extra time added at 10 Mbit/s
	localparam int DUR_10M_EXTRA_NS = 2200;
	localparam int NS_PER_US = 1000;
	localparam int JAM_CNT_W = 18;
	localparam int FIFO_LVL_W = 14;
	localparam int THR_W = 8;
	localparam int CODE_W = 4;

	typedef enum logic [1:0] {AFCANY_IDLE, AFCANY_ABOVE_HI} afcany_fc_t;
	typedef enum logic [1:0] {AFCANY_PNONE, AFCANY_PHI, AFCANY_PZERO} afcany_pend_t;

	// cycles of mclk for a least time in ns, rounded up
	function automatic logic [JAM_CNT_W-1:0] afcany_ns_to_cyc(input int ns);
		int cyc;
		cyc = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
		if (cyc < 1)
			cyc = 1;
		return JAM_CNT_W'(cyc);
	endfunction
endpackage

// [src/afcany_flow_ctl.sv]
`timescale 1ns/10ps
module afcany_flow_ctl
	import afcany_pkg::*;
#(
	parameter int LVL_W = FIFO_LVL_W
)(
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// configuration
	input  wire logic                 flow_ctl_any_frame,
	input  wire logic                 flow_ctl_mcast,
	input  wire logic                 flow_ctl_bcast,
	input  wire logic                 flow_ctl_own_addr,
	input  wire logic [THR_W-1:0]     fifo_high_threshold,
	input  wire logic [THR_W-1:0]     fifo_low_threshold,
	input  wire logic [CODE_W-1:0]    jam_duration_code,
	input  wire logic [15:0]          pause_time_value,
	// mac status
	input  wire logic                 full_duplex,
	input  wire logic                 speed_100,
	input  wire logic                 tx_enable,
	input  wire logic [LVL_W-1:0]     rx_fifo_level,
	// receive frame events
	input  wire logic                 rx_preamble_valid,
	input  wire logic                 rx_frame_mcast,
	input  wire logic                 rx_frame_bcast,
	input  wire logic                 rx_frame_own_addr,
	input  wire logic                 rx_addr_valid,
	// pause transmit handshake
	output logic                      pause_req,
	output logic [15:0]               pause_time,
	input  wire logic                 pause_ack,
	// back pressure
	output logic                      jam_active
);

	afcany_fc_t            fc_q, fc_d;
	afcany_pend_t          pend_q, pend_d;
	logic [JAM_CNT_W-1:0]  jam_cnt_q, jam_cnt_d;
	logic                  jam_q, jam_d;
	logic [15:0]           ptime_q, ptime_d;

	function automatic logic [JAM_CNT_W-1:0] dur_cycles(input logic [CODE_W-1:0] code,
		input logic fast);
		int ns;
		unique case (code)
			4'h0: ns = DUR_CODE0_NS;
			4'h1: ns = DUR_CODE1_NS;
			4'h2: ns = DUR_CODE2_NS;
			4'h3: ns = DUR_CODE3_NS;
			4'h4: ns = DUR_CODE4_NS;
			default: ns = DUR_CODE5_NS + (int'(code) - 5) * DUR_STEP_NS;
		endcase
		if (!fast)
			ns = ns + DUR_10M_EXTRA_NS;
		return afcany_ns_to_cyc(ns);
	endfunction

	// thresholds count 64-byte blocks; shift them into the byte scale of the level
	function automatic logic [LVL_W-1:0] thr_bytes(input logic [THR_W-1:0] thr);
		return LVL_W'({thr, {THR_UNIT_LOG2{1'b0}}});
	endfunction

	wire logic [LVL_W-1:0] hi_bytes  = thr_bytes(fifo_high_threshold);
	wire logic [LVL_W-1:0] lo_bytes  = thr_bytes(fifo_low_threshold);
	wire logic             at_hi     = rx_fifo_level >= hi_bytes;
	wire logic             below_lo  = rx_fifo_level < lo_bytes;
	// no new request while one is pending, so an ack never meets a fresh one
	wire logic             pend_idle = pend_q == AFCANY_PNONE;
	wire logic             ack_now   = !pend_idle && pause_ack;

	// selector match only counts once the address decode has finished
	// any-frame overrides selectors
	wire logic sel_match = rx_addr_valid &&
		((flow_ctl_mcast && rx_frame_mcast) || (flow_ctl_bcast && rx_frame_bcast) ||
		(flow_ctl_own_addr && rx_frame_own_addr));
	wire logic hd_trigger = flow_ctl_any_frame ? rx_preamble_valid : sel_match;
	wire logic fc_enabled = flow_ctl_any_frame || flow_ctl_mcast || flow_ctl_bcast
		|| flow_ctl_own_addr;

	// full-duplex arming at the high level, release below the low level
	wire logic fd_arm     = full_duplex && flow_ctl_any_frame && tx_enable && at_hi &&
		pend_idle;
	// the zero pause waits until the high pause has left the mac
	wire logic fd_release = full_duplex && flow_ctl_any_frame && tx_enable && below_lo &&
		pend_idle;

	// pause path: one high pause per crossing, then one zero pause if full duplex is still on
	always_comb
	begin
		fc_d    = fc_q;
		pend_d  = pend_q;
		ptime_d = ptime_q;
		if (ack_now)
			pend_d = AFCANY_PNONE;
		unique case (fc_q)
			AFCANY_IDLE:
			begin
				if (fd_arm)
				begin
					fc_d    = AFCANY_ABOVE_HI;
					pend_d  = AFCANY_PHI;
					ptime_d = pause_time_value;
				end
			end
			AFCANY_ABOVE_HI:
			begin
				// leaving full duplex drops the episode without a zero pause
				if (!full_duplex)
					fc_d = AFCANY_IDLE;
				else if (fd_release)
				begin
					fc_d    = AFCANY_IDLE;
					pend_d  = AFCANY_PZERO;
					ptime_d = 16'h0000;
				end
			end
			// an illegal state code falls back to idle
			default: fc_d = AFCANY_IDLE;
		endcase
		if (!tx_enable)
			pend_d = AFCANY_PNONE;
	end

	wire logic jam_start = !full_duplex && tx_enable && at_hi && hd_trigger && !jam_q;
	// code and speed are taken at jam start; a change during a jam applies to the next
	// the 18-bit count covers the longest code at 10 Mbit/s
	wire logic [JAM_CNT_W-1:0] jam_load = dur_cycles(jam_duration_code, speed_100);
	wire logic jam_last = jam_q && (jam_cnt_q <= JAM_CNT_W'(1));

	always_comb
	begin
		jam_d     = jam_q;
		jam_cnt_d = jam_cnt_q;
		if (jam_q)
		begin
			jam_cnt_d = jam_cnt_q - 1'b1;
			if (jam_last)
				jam_d = 1'b0;
		end
		if (jam_start && fc_enabled)
		begin
			jam_d     = 1'b1;
			jam_cnt_d = jam_load;
		end
		// dropping the transmitter cuts a jam short; the next start reloads the count
		// silence when transmitter off
		if (!tx_enable)
			jam_d = 1'b0;
	end

	// one process per register keeps each reset value beside its flop
	always_ff @(posedge mclk)
	begin
		if (rst)
			fc_q <= AFCANY_IDLE;
		else
			fc_q <= fc_d;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			pend_q <= AFCANY_PNONE;
		else
			pend_q <= pend_d;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			jam_q <= 1'b0;
		else
			jam_q <= jam_d;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			jam_cnt_q <= '0;
		else
			jam_cnt_q <= jam_cnt_d;
	end

	// the time only changes when a request is loaded, so it stands with pause_req
	always_ff @(posedge mclk)
	begin
		if (rst)
			ptime_q <= 16'h0000;
		else
			ptime_q <= ptime_d;
	end

	// pause only via any-frame in full duplex
	assign pause_req  = pend_q != AFCANY_PNONE;
	assign pause_time = ptime_q;
	assign jam_active = jam_q;

endmodule // afcany_flow_ctl

// [tb/afcany_flow_ctl_monitor.sv]
`timescale 1ns/10ps
module afcany_flow_ctl_monitor
	import afcany_pkg::*;
#(
	parameter int LVL_W = FIFO_LVL_W
)(
	// clock, inputs
	input wire logic             mclk,
	input wire logic             rst,
	input wire logic             flow_ctl_any_frame,
	input wire logic             full_duplex,
	input wire logic             tx_enable,
	input wire logic [THR_W-1:0] fifo_high_threshold,
	input wire logic [LVL_W-1:0] rx_fifo_level,
	input wire logic [15:0]      pause_time_value,
	input wire logic             pause_ack,
	// outputs
	input wire logic             pause_req,
	input wire logic [15:0]      pause_time,
	input wire logic             jam_active
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_rst_quiet: assert property (disable iff (1'b0) rst |=> !pause_req && !jam_active)
		else $error("active after reset");
	a_tx_off: assert property (!tx_enable |=> !pause_req && !jam_active)
		else $error("active with tx off");
	a_req_hold: assert property (
		pause_req && !pause_ack && tx_enable && full_duplex |=> pause_req)
		else $error("request dropped");
	a_req_drop: assert property (pause_req && pause_ack |=> !pause_req)
		else $error("request kept");
	a_time_hold: assert property (
		pause_req && !pause_ack |=> !pause_req || $stable(pause_time))
		else $error("time moved");
	a_pause_cause: assert property (
		$rose(pause_req) |-> $past(full_duplex && flow_ctl_any_frame && tx_enable))
		else $error("pause without cause");
	a_pause_time: assert property (
		$rose(pause_req) |-> pause_time == $past(pause_time_value) || pause_time == 16'h0000)
		else $error("bad pause time");
	a_jam_cause: assert property (
		$rose(jam_active) |->
		$past(!full_duplex && tx_enable && rx_fifo_level >= {fifo_high_threshold, 6'h00}))
		else $error("jam without cause");
	a_fd_no_jam: assert property (full_duplex && !jam_active |=> !jam_active)
		else $error("jam in full duplex");
endmodule // afcany_flow_ctl_monitor

// [tb/afcany_mac_model.sv]
`timescale 1ns/10ps
module afcany_mac_model #(
	parameter int DLY = 3
)(
	// handshake
	input  wire logic mclk,
	input  wire logic pause_req,
	output logic      pause_ack = 1'b0
);
	int cnt = 0;
	always @(posedge mclk)
	begin
		cnt <= (pause_req && !pause_ack) ? cnt + 1 : 0;
		pause_ack <= pause_req && !pause_ack && cnt == DLY;
	end
endmodule // afcany_mac_model

// [tb/auto_flow_control_any_frame_test.sv]
`timescale 1ns/10ps
module auto_flow_control_any_frame_test;
	import afcany_pkg::*;
	logic mclk = 0, rst = 1, flow_ctl_any_frame = 0, full_duplex = 1, speed_100 = 1;
	logic tx_enable = 1, rx_preamble_valid = 0, pause_req, pause_ack, jam_active;
	logic flow_ctl_mcast = 0, flow_ctl_bcast = 0, flow_ctl_own_addr = 0, rx_addr_valid = 0;
	logic rx_frame_mcast = 0, rx_frame_bcast = 0, rx_frame_own_addr = 0;
	logic [7:0] fifo_high_threshold = 8'h04, fifo_low_threshold = 8'h02;
	logic [3:0] jam_duration_code = 4'h0;
	logic [13:0] rx_fifo_level = 14'h0100;
	logic [15:0] pause_time_value = 16'h1234, pause_time;
	int err_count = 0, cmp_count = 0, cyc = 0, n, exp_n;
	always #2.5 mclk = ~mclk;
	afcany_flow_ctl i_afcany_flow_ctl (.*);
	afcany_mac_model i_afcany_mac_model (.*);
	task tick(input int k = 1);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task chk(input string s, input logic [15:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %s exp %h got %h", s, exp, got);
		end
	endtask
	task wt;
		for (n = 0; pause_req !== 1'b1 && n < 50; n++)
			tick();
	endtask
	task end_of_test;
		$display("errors %0d checks %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			end_of_test();
		end
	end
	initial
	begin
		tick(16);
		rst = 0;
		tick(20);
		chk("pause", pause_req, 0);
		flow_ctl_any_frame = 1;
		wt();
		chk("latency", n, 1);
		chk("time", pause_time, 16'h1234);
		tick(10);
		chk("single", pause_req, 0);
		rx_fifo_level = 14'h0040;
		wt();
		chk("zero", pause_time, 16'h0000);
		tick(10);
		full_duplex = 0;
		rx_fifo_level = 14'h0100;
		{flow_ctl_mcast, rx_frame_mcast, rx_addr_valid} = 3'h7;
		tick();
		rx_addr_valid = 0;
		tick();
		chk("selector", jam_active, 0);
		for (int i = 0; i < 3; i++)
		begin
			speed_100 = i != 0;
			jam_duration_code = (i == 2) ? 4'h5 : i[3:0];
			exp_n = (i == 0) ? DUR_CODE0_NS + DUR_10M_EXTRA_NS : DUR_CODE1_NS;
			if (i == 2)
				exp_n = DUR_CODE5_NS;
			rx_preamble_valid = 1;
			tick();
			rx_preamble_valid = 0;
			for (n = 0; jam_active === 1'b1 && n < 30000; n++)
				tick();
			chk("jam", n, exp_n * CLK_MHZ / NS_PER_US);
		end
		rx_preamble_valid = 1;
		tick();
		rx_preamble_valid = 0;
		chk("jam on", jam_active, 1);
		tx_enable = 0;
		tick(2);
		chk("cut", jam_active, 0);
		rx_preamble_valid = 1;
		tick();
		rx_preamble_valid = 0;
		full_duplex = 1;
		tick(5);
		chk("off", jam_active | pause_req, 0);
		end_of_test();
	end
endmodule // auto_flow_control_any_frame_test
bind afcany_flow_ctl afcany_flow_ctl_monitor #(.LVL_W(LVL_W)) i_afcany_flow_ctl_monitor (.*);
